// ---- verilog/wsw_pkg.sv ----
// Constants, state codes and carrier types of the watchdog, sleep and wake controller.
// Assumes one 10 MHz clock, a synchronous active-high reset and a core sequencer beside it.

package wsw_pkg;

  localparam logic [13:0] STATUS_ADDR = 14'h0003;
  localparam logic [13:0] OPTION_ADDR = 14'h0081;
  localparam logic [13:0] OPTION_MIRROR_ADDR = 14'h0181;
  localparam logic [13:0] CONFIG_ADDR = 14'h2007;
  localparam logic [6:0] COMMON_BASE = 7'h70;
  localparam int COMMON_DEPTH = 16;

  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam int OPT_PSA_BIT = 3;
  localparam int CFG_WATCHDOG_ENABLE_CFG_BIT = 3;
  localparam int STAT_TO_BIT = 4;
  localparam int STAT_PD_BIT = 3;
  localparam int STAT_WDTRST_BIT = 0;

  localparam logic [2:0] FOSC_LP = 3'h0;
  localparam logic [2:0] FOSC_XT = 3'h1;
  localparam logic [2:0] FOSC_HS = 3'h2;

  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  localparam int CLK_PERIOD_NS = 100;
  localparam int TOSC_NS = 100;
  localparam int OST_TOSC = 1024;
  localparam int OST_CYCLES = (OST_TOSC * TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_OST = 2'b10,
    ST_RESUME = 2'b11
  } wsw_state_t;

  typedef struct packed {
    logic sleepExec;
    logic watchdogClearInstr;
    logic globalIrqEnable;
    logic [12:0] pc;
  } wsw_core_cmd_t;

  typedef struct packed {
    logic pcLoad;
    logic [12:0] pcValue;
    logic stackPush;
    logic [12:0] pushValue;
    logic gieClear;
  } wsw_seq_ctl_t;

endpackage

// ---- verilog/wsw_watchdog_sleep_wake_ctrl.sv ----
// Watchdog timer, power-down sequencing, wake decision and interrupt entry for the core.
// Assumes the core sequencer reacts to the control outputs on the next clock edge.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps

module wsw_watchdog_sleep_wake_ctrl #(
  parameter int NIRQ = 8,
  parameter int IO_W = 15,
  parameter logic [NIRQ-1:0] WAKE_CAPABLE = '1,
  parameter int WDT_RC_DIV = 8,
  parameter int WDT_BASE_TICKS = 256
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [13:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic [7:0] cfgWordIn,
  input wire wsw_pkg::wsw_core_cmd_t core,
  input wire logic [NIRQ-1:0] irqFlag,
  input wire logic [NIRQ-1:0] irqEnable,
  input wire logic masterClearN,
  input wire logic [IO_W-1:0] ioOutIn,
  input wire logic [IO_W-1:0] ioOeIn,
  output logic [IO_W-1:0] ioOut,
  output logic [IO_W-1:0] ioOe,
  output wsw_pkg::wsw_seq_ctl_t seqCtl,
  output logic prefetchReq,
  output logic [12:0] prefetchAddr,
  output logic execPrefetched,
  output logic coreHalt,
  output logic oscDriverOn,
  output logic deviceReset,
  output logic wdtResetFlag,
  output logic timeoutFlagN,
  output logic powerdownFlagN
);

  localparam int RC_W = $clog2(WDT_RC_DIV);
  localparam int BASE_W = $clog2(WDT_BASE_TICKS);
  localparam int OST_W = $clog2(wsw_pkg::OST_CYCLES + 1);

  // The watchdog period is not fixed by the device, so both figures stay parameters.
  if (NIRQ < 1 || IO_W < 1 || WDT_RC_DIV < 2 || WDT_BASE_TICKS < 2 || WDT_BASE_TICKS > 65536)
  begin : paramCheck
    $error("wsw_watchdog_sleep_wake_ctrl: parameter out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  function automatic logic isCommon(input logic [13:0] addr);
    isCommon = (addr[13:9] == 5'h00) && (addr[6:0] >= wsw_pkg::COMMON_BASE);
  endfunction

  function automatic logic isOption(input logic [13:0] addr);
    isOption = (addr == wsw_pkg::OPTION_ADDR) || (addr == wsw_pkg::OPTION_MIRROR_ADDR);
  endfunction

  function automatic logic [7:0] postLimitOf(input logic [7:0] opt);
    if (opt[wsw_pkg::OPT_PSA_BIT])
    begin
      postLimitOf = 8'(1 << opt[2:0]);
    end
    else
    begin
      postLimitOf = 8'h01;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and internal signals.

  wsw_pkg::wsw_state_t state;
  logic [7:0] timerOptionControl;
  logic [7:0] deviceConfigurationWord;
  logic [7:0] commonRam [wsw_pkg::COMMON_DEPTH];
  logic [RC_W-1:0] rcDiv;
  logic rcTick;
  logic [BASE_W-1:0] baseCount;
  logic [7:0] postCount;
  logic [OST_W-1:0] ostCount;
  logic watchdogEnableCfg;
  logic pending;
  logic wakeIrq;
  logic sleepEffective;
  logic wdtExpire;
  logic needOst;

  assign watchdogEnableCfg = deviceConfigurationWord[wsw_pkg::CFG_WATCHDOG_ENABLE_CFG_BIT];
  assign pending = |(irqFlag & irqEnable);
  assign wakeIrq = |(irqFlag & irqEnable & WAKE_CAPABLE);
  // A sleep that finds an enabled request already pending neither enters sleep nor sets the flags; only the prefetch still happens.
  assign sleepEffective = (state == wsw_pkg::ST_RUN) && core.sleepExec && !pending;
  // At or past the limit: a ratio lowered by software must not let the count run on for a full wrap.
  assign wdtExpire = watchdogEnableCfg && rcTick && (baseCount == BASE_W'(WDT_BASE_TICKS - 1))
                     && (postCount >= postLimitOf(timerOptionControl) - 8'h01);
  assign needOst = (deviceConfigurationWord[2:0] == wsw_pkg::FOSC_LP)
                   || (deviceConfigurationWord[2:0] == wsw_pkg::FOSC_XT)
                   || (deviceConfigurationWord[2:0] == wsw_pkg::FOSC_HS);

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog oscillator and counter.

  // The divider stands in for the watchdog's own oscillator and is never gated by sleep.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rcDiv <= '0;
      rcTick <= 1'b0;
    end
    else
    begin
      rcTick <= (rcDiv == RC_W'(WDT_RC_DIV - 1));
      rcDiv <= (rcDiv == RC_W'(WDT_RC_DIV - 1)) ? '0 : rcDiv + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || !watchdogEnableCfg)
    begin
      baseCount <= '0;
      postCount <= 8'h00;
    end
    else if (sleepEffective || (state == wsw_pkg::ST_RUN && core.watchdogClearInstr))
    begin
      baseCount <= '0;
      postCount <= 8'h00;
    end
    else if (rcTick)
    begin
      if (baseCount == BASE_W'(WDT_BASE_TICKS - 1))
      begin
        baseCount <= '0;
        postCount <= wdtExpire ? 8'h00 : postCount + 8'h01;
      end
      else
      begin
        baseCount <= baseCount + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep and wake sequencing.

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= wsw_pkg::ST_RUN;
      ostCount <= '0;
      deviceReset <= 1'b0;
      coreHalt <= 1'b0;
      oscDriverOn <= 1'b1;
      execPrefetched <= 1'b0;
    end
    else
    begin
      deviceReset <= 1'b0;
      execPrefetched <= 1'b0;
      if (!masterClearN)
      begin
        deviceReset <= 1'b1;
        state <= wsw_pkg::ST_RUN;
        coreHalt <= 1'b0;
        oscDriverOn <= 1'b1;
      end
      else
      begin
        case (state)
          wsw_pkg::ST_RUN:
          begin
            if (wdtExpire)
            begin
              deviceReset <= 1'b1;
            end
            else if (sleepEffective)
            begin
              state <= wsw_pkg::ST_SLEEP;
              coreHalt <= 1'b1;
              oscDriverOn <= 1'b0;
            end
          end
          wsw_pkg::ST_SLEEP:
          begin
            // A wake source already present on entry wakes on the first sleep cycle.
            if (wdtExpire || wakeIrq)
            begin
              oscDriverOn <= 1'b1;
              ostCount <= '0;
              state <= needOst ? wsw_pkg::ST_OST : wsw_pkg::ST_RESUME;
            end
          end
          wsw_pkg::ST_OST:
          begin
            ostCount <= ostCount + 1'b1;
            if (ostCount == OST_W'(wsw_pkg::OST_CYCLES - 1))
            begin
              state <= wsw_pkg::ST_RESUME;
            end
          end
          wsw_pkg::ST_RESUME:
          begin
            // The prefetched instruction runs first; a still pending request then vectors.
            execPrefetched <= 1'b1;
            coreHalt <= 1'b0;
            state <= wsw_pkg::ST_RUN;
          end
          default:
          begin
            state <= wsw_pkg::ST_RUN;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags.

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      timeoutFlagN <= 1'b1;
      powerdownFlagN <= 1'b1;
    end
    else if (wdtExpire)
    begin
      timeoutFlagN <= 1'b0;
    end
    else if (sleepEffective)
    begin
      timeoutFlagN <= 1'b1;
      powerdownFlagN <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || !masterClearN)
    begin
      wdtResetFlag <= 1'b0;
    end
    else if (state == wsw_pkg::ST_RUN && wdtExpire)
    begin
      wdtResetFlag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin hold, prefetch and interrupt entry.

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ioOut <= '0;
      ioOe <= '0;
    end
    else if (!sleepEffective && state != wsw_pkg::ST_SLEEP && state != wsw_pkg::ST_OST)
    begin
      ioOut <= ioOutIn;
      ioOe <= ioOeIn;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prefetchReq <= 1'b0;
      prefetchAddr <= 13'h0000;
    end
    else
    begin
      prefetchReq <= (state == wsw_pkg::ST_RUN) && core.sleepExec;
      if (state == wsw_pkg::ST_RUN && core.sleepExec)
      begin
        prefetchAddr <= core.pc + 13'h0001;
      end
    end
  end

  // The previous entry blocks a second one until the core has dropped its global enable.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      seqCtl <= '0;
    end
    else
    begin
      seqCtl <= '0;
      if (state == wsw_pkg::ST_RUN && masterClearN && !wdtExpire && !core.sleepExec
          && core.globalIrqEnable && pending && !seqCtl.gieClear)
      begin
        seqCtl.gieClear <= 1'b1;
        seqCtl.stackPush <= 1'b1;
        seqCtl.pushValue <= core.pc;
        seqCtl.pcLoad <= 1'b1;
        seqCtl.pcValue <= wsw_pkg::IRQ_VECTOR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port.

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      deviceConfigurationWord <= cfgWordIn;
      timerOptionControl <= wsw_pkg::OPTION_RESET;
    end
    else if (regWr && isOption(regAddr))
    begin
      timerOptionControl <= regWdata;
    end
  end

  // Common bytes hold no reset value, like ordinary data memory.
  always_ff @(posedge clk)
  begin
    if (regWr && isCommon(regAddr))
    begin
      commonRam[regAddr[3:0]] <= regWdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || !regRd)
    begin
      regRdata <= 8'h00;
    end
    else if (isCommon(regAddr))
    begin
      regRdata <= commonRam[regAddr[3:0]];
    end
    else if (isOption(regAddr))
    begin
      regRdata <= timerOptionControl;
    end
    else if (regAddr == wsw_pkg::CONFIG_ADDR)
    begin
      regRdata <= deviceConfigurationWord;
    end
    else if (regAddr == wsw_pkg::STATUS_ADDR)
    begin
      regRdata <= {3'h0, timeoutFlagN, powerdownFlagN, 2'h0, wdtResetFlag};
    end
    else
    begin
      regRdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  sleep_as_nop_a: assert property (@(posedge clk) disable iff (rst)
    (state == wsw_pkg::ST_RUN && core.sleepExec && pending && masterClearN && !wdtExpire)
    |=> (state == wsw_pkg::ST_RUN) && $stable(powerdownFlagN) && $stable(timeoutFlagN))
    else $error("sleep with pending request changed state or flags");

  wdt_reset_a: assert property (@(posedge clk) disable iff (rst)
    (state == wsw_pkg::ST_RUN && wdtExpire && masterClearN)
    |=> deviceReset && wdtResetFlag && !timeoutFlagN)
    else $error("awake watchdog time-out did not reset");

  wdt_wake_a: assert property (@(posedge clk) disable iff (rst)
    (state == wsw_pkg::ST_SLEEP && wdtExpire && masterClearN)
    |=> !deviceReset && (state != wsw_pkg::ST_SLEEP) && !timeoutFlagN)
    else $error("sleeping watchdog time-out did not wake");

  sleep_flags_a: assert property (@(posedge clk) disable iff (rst)
    (sleepEffective && !wdtExpire && masterClearN)
    |=> !powerdownFlagN && timeoutFlagN && !oscDriverOn && coreHalt)
    else $error("sleep entry flags or oscillator wrong");

  pin_hold_a: assert property (@(posedge clk) disable iff (rst)
    (state == wsw_pkg::ST_SLEEP && $past(state) == wsw_pkg::ST_SLEEP)
    |-> $stable(ioOut) && $stable(ioOe))
    else $error("pins changed during sleep");

  wdt_off_a: assert property (@(posedge clk) disable iff (rst)
    !watchdogEnableCfg |=> (baseCount == '0) && (postCount == 8'h00) && !wdtExpire)
    else $error("disabled watchdog counted");

  wdt_clear_a: assert property (@(posedge clk) disable iff (rst)
    sleepEffective |=> (baseCount == '0) && (postCount == 8'h00))
    else $error("sleep did not clear the watchdog");

  ost_wait_a: assert property (@(posedge clk) disable iff (rst)
    (state == wsw_pkg::ST_SLEEP ##1 state == wsw_pkg::ST_OST && masterClearN)
    |-> (state == wsw_pkg::ST_OST && coreHalt && !execPrefetched) [*8])
    else $error("start-up wait cut short");

  prefetch_a: assert property (@(posedge clk) disable iff (rst)
    (state == wsw_pkg::ST_RUN && core.sleepExec)
    |=> prefetchReq && (prefetchAddr == $past(core.pc) + 13'h0001))
    else $error("wrong prefetch address");

  vector_a: assert property (@(posedge clk) disable iff (rst)
    seqCtl.pcLoad |-> (seqCtl.pcValue == wsw_pkg::IRQ_VECTOR) && seqCtl.gieClear
    && seqCtl.stackPush && (seqCtl.pushValue == $past(core.pc)))
    else $error("interrupt entry incomplete");

  master_clear_n_sleep_a: assert property (@(posedge clk) disable iff (rst)
    (state == wsw_pkg::ST_SLEEP && !masterClearN) |=> deviceReset && !coreHalt)
    else $error("master clear in sleep did not reset");

  irq_wake_a: assert property (@(posedge clk) disable iff (rst)
    (state == wsw_pkg::ST_SLEEP && wakeIrq && masterClearN)
    |=> (state != wsw_pkg::ST_SLEEP) && oscDriverOn)
    else $error("enabled interrupt did not wake");

endmodule

// ---- testbench/wsw_core_model.sv ----
// Behavioural model of the core sequencer that drives the controller's core port.
// Assumes the bench asks for sleep and for global enable with one-cycle pulses.
`timescale 1ns/1ps

module wsw_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire wsw_pkg::wsw_seq_ctl_t seqCtl,
  input wire logic sleepReq,
  input wire logic gieSet,
  input wire logic [12:0] pcIn,
  output wsw_pkg::wsw_core_cmd_t core
);
  ////////////////////////////////////////////////////////////////////////////////
  // Every sleep is preceded by a watchdog clear, so a peripheral wake never meets a stale count.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      core <= '0;
    end
    else
    begin
      core.watchdogClearInstr <= sleepReq;
      core.sleepExec <= core.watchdogClearInstr;
      core.globalIrqEnable <= seqCtl.gieClear ? 1'b0 : (gieSet | core.globalIrqEnable);
      core.pc <= seqCtl.pcLoad ? seqCtl.pcValue : pcIn;
    end
  end
endmodule

// ---- testbench/watchdog_sleep_wake_ctrl_tb.sv ----
// Self-checking bench of the watchdog, sleep and wake controller.
// Assumes the shortened watchdog (8 clocks a base period) and a 10 MHz clock.
`timescale 1ns/1ps

module watchdog_sleep_wake_ctrl_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] regAddr = '0;
  logic [7:0] regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic [7:0] cfgWordIn = 8'h0C;
  wsw_pkg::wsw_core_cmd_t core;
  logic [7:0] irqFlag = '0;
  logic [7:0] irqEnable = '0;
  logic masterClearN = 1'b1;
  logic [14:0] ioOutIn = '0;
  logic [14:0] ioOeIn = '0;
  logic [14:0] ioOut;
  logic [14:0] ioOe;
  wsw_pkg::wsw_seq_ctl_t seqCtl;
  logic prefetchReq;
  logic [12:0] prefetchAddr;
  logic execPrefetched;
  logic coreHalt;
  logic oscDriverOn;
  logic deviceReset;
  logic wdtResetFlag;
  logic timeoutFlagN;
  logic powerdownFlagN;
  logic sleepReq = 1'b0;
  logic gieSet = 1'b0;
  logic [12:0] pcIn = '0;
  int failCount = 0;
  int checkCount = 0;
  int cycles = 0;
  int n;
  logic [7:0] v;

  always #50 clk = ~clk;

  // Source 7 stands for a clocked peripheral that must not wake the device.
  wsw_watchdog_sleep_wake_ctrl #(.WAKE_CAPABLE(8'h7F), .WDT_RC_DIV(2), .WDT_BASE_TICKS(4)) DUT (.clk(clk), .rst(rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .cfgWordIn(cfgWordIn), .core(core), .irqFlag(irqFlag), .irqEnable(irqEnable),
    .masterClearN(masterClearN), .ioOutIn(ioOutIn), .ioOeIn(ioOeIn), .ioOut(ioOut), .ioOe(ioOe),
    .seqCtl(seqCtl), .prefetchReq(prefetchReq), .prefetchAddr(prefetchAddr),
    .execPrefetched(execPrefetched), .coreHalt(coreHalt), .oscDriverOn(oscDriverOn),
    .deviceReset(deviceReset), .wdtResetFlag(wdtResetFlag), .timeoutFlagN(timeoutFlagN),
    .powerdownFlagN(powerdownFlagN));

  wsw_core_model partner (.clk(clk), .rst(rst), .seqCtl(seqCtl), .sleepReq(sleepReq),
    .gieSet(gieSet), .pcIn(pcIn), .core(core));

  ////////////////////////////////////////////////////////////////////////////////
  task conclude();
    if (failCount == 0 && checkCount > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask

  // A hung wait must still reach the verdict.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      failCount++;
      conclude();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      failCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Expected status byte, built from the flag positions of the package.
  function automatic logic [7:0] statusByte(input logic to, input logic pd, input logic wdtRst);
    statusByte = 8'h00;
    statusByte[wsw_pkg::STAT_TO_BIT] = to;
    statusByte[wsw_pkg::STAT_PD_BIT] = pd;
    statusByte[wsw_pkg::STAT_WDTRST_BIT] = wdtRst;
  endfunction

  task doReset(input logic [7:0] cfg);
    @(posedge clk);
    rst <= 1'b1;
    cfgWordIn <= cfg;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask

  task wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task rd(input logic [13:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk(regRdata, exp);
  endtask

  // Returns at the negative edge after the controller has taken the sleep pulse.
  task doSleep();
    @(posedge clk);
    sleepReq <= 1'b1;
    @(posedge clk);
    sleepReq <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task waitExec(output int k);
    k = 0;
    while (execPrefetched !== 1'b1 && k < 1200)
    begin
      @(negedge clk);
      k++;
    end
  endtask

  task waitReset(input int lim, output int k);
    k = 0;
    while (deviceReset !== 1'b1 && k < lim)
    begin
      @(negedge clk);
      k++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Sleep, a blocked then an enabled interrupt, and the wake that follows.
  task irqWake(input logic global_irq_enable, input int lo, input int hi);
    logic [12:0] pc;
    logic [14:0] io;
    int k;
    pc = 13'($urandom);
    io = 15'($urandom);
    @(posedge clk);
    pcIn <= pc;
    ioOutIn <= io;
    ioOeIn <= ~io;
    gieSet <= global_irq_enable;
    @(posedge clk);
    gieSet <= 1'b0;
    doSleep();
    chk({coreHalt, oscDriverOn}, 2'b10);
    chk({powerdownFlagN, timeoutFlagN}, 2'b01);
    chk({prefetchReq, prefetchAddr}, {1'b1, pc + 13'h0001});
    @(posedge clk);
    ioOutIn <= ~io;
    ioOeIn <= io;
    irqFlag <= 8'h84;
    irqEnable <= 8'h80;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk({ioOut, ioOe}, {io, ~io});
    chk(coreHalt, 1'b1);
    @(posedge clk);
    irqEnable <= 8'h84;
    waitExec(k);
    chk(k >= lo && k <= hi, 1'b1);
    chk({powerdownFlagN, timeoutFlagN}, 2'b01);
    k = 0;
    while (seqCtl.pcLoad !== 1'b1 && k < 6)
    begin
      @(negedge clk);
      k++;
    end
    chk(seqCtl.pcLoad, global_irq_enable);
    if (global_irq_enable)
    begin
      chk(seqCtl.pcValue, wsw_pkg::IRQ_VECTOR);
      chk({seqCtl.stackPush, seqCtl.gieClear, seqCtl.pushValue}, {2'b11, pc});
    end
    @(posedge clk);
    irqFlag <= '0;
    irqEnable <= '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(20829));
    doReset(8'h0C);
    @(negedge clk);
    chk({oscDriverOn, powerdownFlagN, timeoutFlagN, deviceReset}, 4'hE);
    rd(14'h0081, 8'hFF);
    rd(14'h2007, 8'h0C);
    rd(14'h0003, statusByte(1'b1, 1'b1, 1'b0));
    // The ratio bits stay at the slowest setting so the running watchdog cannot fire meanwhile.
    v = 8'($urandom) | 8'h0F;
    wr(14'h0181, v);
    rd(14'h0081, v);
    wr(14'h0081, 8'hFF);
    wr(14'h2007, 8'h00);
    rd(14'h2007, 8'h0C);
    rd(14'h1000, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($urandom);
      wr({5'h00, 2'(i), 7'h70 + 7'(i * 5)}, v);
      rd({5'h00, 2'(i + 1), 7'h70 + 7'(i * 5)}, v);
    end
    // An enabled request already pending turns the sleep into a no-operation.
    @(posedge clk);
    irqFlag <= 8'h02;
    irqEnable <= 8'h02;
    doSleep();
    chk({coreHalt, powerdownFlagN, timeoutFlagN, prefetchReq}, 4'h7);
    @(posedge clk);
    irqFlag <= '0;
    irqEnable <= '0;
    irqWake(1'b0, 1, 5);
    irqWake(1'b1, 1, 5);
    // A short watchdog period: 8 base ticks of 8 clocks.
    wr(14'h0081, 8'h0B);
    doSleep();
    waitExec(n);
    chk(n < 100, 1'b1);
    chk({timeoutFlagN, wdtResetFlag, deviceReset}, 3'b000);
    waitReset(100, n);
    chk(n < 100, 1'b1);
    chk({wdtResetFlag, timeoutFlagN}, 2'b10);
    rd(14'h0003, statusByte(1'b0, 1'b0, 1'b1));
    doSleep();
    @(posedge clk);
    masterClearN <= 1'b0;
    waitReset(4, n);
    chk(n < 4, 1'b1);
    @(negedge clk);
    chk(wdtResetFlag, 1'b0);
    @(posedge clk);
    masterClearN <= 1'b1;
    // Crystal mode with the watchdog disabled by configuration.
    doReset(8'h01);
    irqWake(1'b0, 1024, 1030);
    waitReset(1100, n);
    chk(n, 1100);
    conclude();
  end
endmodule
